//--- gsc_counter.sv
// Gated sixteen-bit counter with capture/compare time base, AXI4-Lite.
// Overview of operation
// - Arm flag set after single-pulse enable opens counting on next edge.
// - Pulse trailing edge clears arm flag and blocks further gate counting.
// - Clearing single-pulse enable also clears the arm flag.
// - Toggle and single-pulse modes together count one full gate cycle.
// - Gate level status always shows current gate level, gate enable or not.
// - Falling gate level sets gate event flag and may request interrupt.
// - Gate event flag works with gate count enable cleared.
// - Counter rolls from ffff to 0000 and sets overflow flag.
// - Overflow interrupt needs run and all three enables; flag is sticky.
// - In sleep only unsynchronised external counting; overflow wakes part.
// - Capture event copies the count into the capture/compare pair.
// - Compare mode fires an event when pair equals the count.
// - Special trigger clears count without setting overflow flag.
// - Pair acts as period register under the special trigger.
// - Count byte write wins over a coincident special trigger.
// - Source select: 11 sense, 10 pin or crystal, 01 sys, 00 instr.
// - Prescale select divides by 1, 2, 4 or 8.
// - Skip-sync bit chooses sync for external sources, ignored otherwise.
// - External pin needs a falling edge before the first counted rise.
// - Counter run enables counting; clearing it clears gate toggle.
// - With gate enable, count only while gate at selected polarity.
// - Writing either count byte clears the prescale counter.
`timescale 1ns/1ps
`default_nettype none
module gsc_counter
  import gsc_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              arst_n,
  // AXI4-Lite write address and data.
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response.
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read.
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Pins from outside the clock domain.
  input  wire logic              extCountPin,
  input  wire logic              crystalClk,
  input  wire logic              senseOscClk,
  input  wire logic              gatePin,
  // Same-clock system signals.
  input  wire logic              captureEvent,
  input  wire logic              sleepMode,
  // Events out.
  output logic                   compareEvent,
  output logic                   irqRequest,
  output logic                   wakeUp
);

  // Register state.
  logic [7:0]  ctrl_q;
  logic [4:1]  gateCfg_q;
  logic        arm_q;
  logic [15:0] cnt_q;
  logic [15:0] ccp_q;
  logic [2:0]  mode_q;
  logic        ovf_q, gev_q, cmpf_q;
  logic [3:0]  ien_q;

  // Bus channel state.
  logic              awPend_q, wPend_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [DATA_W-1:0] wData_q;
  logic [3:0]        wStrb_q;
  logic [DATA_W-1:0] rdata_q;

  // Input and edge state.
  logic [3:0] pinSync;
  logic [3:0] pinPrev_q;
  logic [1:0] div_q;
  logic       extPrimed_q, rawDly_q;
  logic       gateInPrev_q, gateSrcPrev_q, gateLvlPrev_q;
  logic       toggle_q, spOpen_q, cmpPrev_q;

  // True when an address selects the given register.
  function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] off);
    regHit = (a[7:2] == off[7:2]);
  endfunction : regHit

  // True when an address selects any implemented register.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[7:2] <= OFF_IEN[7:2]);
  endfunction : mapped

  gsc_sync #(.W(4)) uSync (
    .clk     (clk),
    .arst_n  (arst_n),
    .asyncIn ({gatePin, senseOscClk, crystalClk, extCountPin}),
    .syncOut (pinSync)
  );

  // Control fields.
  wire       run      = ctrl_q[CTRL_RUN];
  wire       skipSync = ctrl_q[CTRL_SKIP];
  wire       xtalEn   = ctrl_q[CTRL_XTAL];
  wire [1:0] psSel    = ctrl_q[CTRL_PS_LO +: 2];
  wire [1:0] csSel    = ctrl_q[CTRL_CS_LO +: 2];
  wire       gateEn   = gateCfg_q[GATE_EN - 3];
  wire       gatePol  = gateCfg_q[GATE_POL - 3];
  wire       tglEn    = gateCfg_q[GATE_TGL - 3];
  wire       spmEn    = gateCfg_q[GATE_SPM - 3];

  // Bus write decode.
  wire doWrite = awPend_q && wPend_q && !bvalid;
  wire wrCtrl  = doWrite && regHit(awAddr_q, OFF_CTRL)  && wStrb_q[0];
  wire wrGate  = doWrite && regHit(awAddr_q, OFF_GATE)  && wStrb_q[0];
  wire wrCntL  = doWrite && regHit(awAddr_q, OFF_CNTL)  && wStrb_q[0];
  wire wrCntH  = doWrite && regHit(awAddr_q, OFF_CNTH)  && wStrb_q[0];
  wire wrCcpL  = doWrite && regHit(awAddr_q, OFF_CCP)   && wStrb_q[0];
  wire wrCcpH  = doWrite && regHit(awAddr_q, OFF_CCP)   && wStrb_q[1];
  wire wrMode  = doWrite && regHit(awAddr_q, OFF_CMODE) && wStrb_q[0];
  wire wrFlags = doWrite && regHit(awAddr_q, OFF_FLAGS) && wStrb_q[0];
  wire wrIen   = doWrite && regHit(awAddr_q, OFF_IEN)   && wStrb_q[0];
  wire wrCnt   = wrCntL || wrCntH;

  // Source edges from the synchronised pins.
  wire extRise   = pinSync[0] && !pinPrev_q[0];
  wire extFall   = !pinSync[0] && pinPrev_q[0];
  wire xtalRise  = pinSync[1] && !pinPrev_q[1];
  wire senseRise = pinSync[2] && !pinPrev_q[2];
  wire instrTick = (div_q == INSTR_LAST);
  wire extTick   = xtalEn ? xtalRise : (extRise && extPrimed_q);
  wire rawTick   = csSel[0] ? senseRise : extTick;
  // External sources get an extra sampling stage unless skipped.
  wire outerTick = skipSync ? rawTick : rawDly_q;
  wire srcTick   = (csSel == CS_INSTR) ? instrTick :
                   (csSel == CS_SYS)   ? 1'b1 : outerTick;

  // Gate path: polarity, toggle stage, single-pulse stage.
  wire gateIn    = gatePol ? pinSync[3] : !pinSync[3];
  wire gateInUp  = gateIn && !gateInPrev_q;
  wire gateSrc   = tglEn ? toggle_q : gateIn;
  wire gateSrcUp = gateSrc && !gateSrcPrev_q;
  wire gateSrcDn = !gateSrc && gateSrcPrev_q;
  wire spDone    = spmEn && spOpen_q && gateSrcDn;
  wire gateLevel = spmEn ? spOpen_q : gateSrc;
  wire gateFell  = !gateLevel && gateLvlPrev_q;

  // Count enable and increment.
  wire sleepOk  = !sleepMode || (csSel[1] && skipSync);
  wire countOn  = run && sleepOk && (!gateEn || gateLevel);
  wire inc;
  gsc_prescaler uPresc (
    .clk    (clk),
    .arst_n (arst_n),
    .clear  (wrCnt),
    .sel    (psSel),
    .tick   (srcTick && countOn),
    .inc    (inc)
  );

  // Compare and trigger decode.
  wire cmpHit   = mode_q[MODE_CMP] && (cnt_q == ccp_q);
  wire cmpFire  = cmpHit && !cmpPrev_q;
  wire trig     = cmpFire && mode_q[MODE_TRIG];
  wire rollOver = inc && (cnt_q == CNT_MAX) && !trig;
  wire capTake  = captureEvent && mode_q[MODE_CAP];

  // Interrupt and wake requests.
  wire ovfReq = run && ovf_q && ien_q[IEN_OVF] && ien_q[IEN_PERI];
  wire gevReq = gev_q && ien_q[IEN_GEV] && ien_q[IEN_PERI];
  assign irqRequest   = (ovfReq || gevReq) && ien_q[IEN_GLOB];
  assign wakeUp       = sleepMode && ovfReq;
  assign compareEvent = cmpFire;

  // Bus handshakes.
  assign awready = !awPend_q && !bvalid;
  assign wready  = !wPend_q && !bvalid;
  assign arready = !rvalid;
  assign rdata   = rdata_q;

  // Read data selection.
  logic [DATA_W-1:0] rdMux;
  always_comb
  begin
    rdMux = '0;
    if (regHit(araddr, OFF_CTRL))
      rdMux[7:0] = ctrl_q & 8'hfd;
    else if (regHit(araddr, OFF_GATE))
      rdMux[7:0] = {gateCfg_q, arm_q, gateLevel, 2'h0};
    else if (regHit(araddr, OFF_CNTL))
      rdMux[7:0] = cnt_q[7:0];
    else if (regHit(araddr, OFF_CNTH))
      rdMux[7:0] = cnt_q[15:8];
    else if (regHit(araddr, OFF_CCP))
      rdMux[15:0] = ccp_q;
    else if (regHit(araddr, OFF_CMODE))
      rdMux[2:0] = mode_q;
    else if (regHit(araddr, OFF_FLAGS))
      rdMux[2:0] = {cmpf_q, gev_q, ovf_q};
    else if (regHit(araddr, OFF_IEN))
      rdMux[3:0] = ien_q;
  end

  // Bus write channel state.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awPend_q <= 1'b0;
      wPend_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= '0;
      wStrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awPend_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        wPend_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite)
      begin
        awPend_q <= 1'b0;
        wPend_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= mapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Bus read channel state.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rvalid  <= 1'b0;
      rdata_q <= '0;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid  <= 1'b1;
      rdata_q <= rdMux;
      rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end

  // Configuration registers.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q    <= CTRL_RST;
      gateCfg_q <= GATE_RST[7:4];
      mode_q    <= 3'h0;
      ien_q     <= 4'h0;
    end
    else
    begin
      if (wrCtrl)
        ctrl_q <= wData_q[7:0] & 8'hfd;
      if (wrGate)
        gateCfg_q <= wData_q[7:4];
      if (wrMode)
        mode_q <= wData_q[2:0];
      if (wrIen)
        ien_q <= wData_q[3:0];
    end
  end

  // Single-pulse arm flag and pulse window.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      arm_q    <= 1'b0;
      spOpen_q <= 1'b0;
    end
    else
    begin
      if (wrGate)
        arm_q <= wData_q[GATE_ARM] && wData_q[GATE_SPM];
      else if (spDone)
        arm_q <= 1'b0;
      if (!spmEn || spDone)
        spOpen_q <= 1'b0;
      else if (arm_q && gateSrcUp)
        spOpen_q <= 1'b1;
    end
  end

  // Edge history, toggle stage and instruction clock divider.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinPrev_q     <= 4'h0;
      div_q         <= 2'h0;
      extPrimed_q   <= 1'b0;
      rawDly_q      <= 1'b0;
      gateInPrev_q  <= 1'b0;
      gateSrcPrev_q <= 1'b0;
      gateLvlPrev_q <= 1'b0;
      toggle_q      <= 1'b0;
      cmpPrev_q     <= 1'b0;
    end
    else
    begin
      pinPrev_q     <= pinSync;
      div_q         <= 2'(div_q + 2'h1);
      rawDly_q      <= rawTick;
      gateInPrev_q  <= gateIn;
      gateSrcPrev_q <= gateSrc;
      gateLvlPrev_q <= gateLevel;
      cmpPrev_q     <= cmpHit;
      if (!run || csSel != CS_EXT)
        extPrimed_q <= 1'b0;
      else if (extFall)
        extPrimed_q <= 1'b1;
      if (!run || !tglEn)
        toggle_q <= 1'b0;
      else if (gateInUp)
        toggle_q <= !toggle_q;
    end
  end

  // Count, capture/compare pair and flags.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q  <= CNT_RST;
      ccp_q  <= CCP_RST;
      ovf_q  <= 1'b0;
      gev_q  <= 1'b0;
      cmpf_q <= 1'b0;
    end
    else
    begin
      if (wrCnt)
      begin
        if (wrCntL)
          cnt_q[7:0] <= wData_q[7:0];
        if (wrCntH)
          cnt_q[15:8] <= wData_q[7:0];
      end
      else if (trig)
        cnt_q <= CNT_RST;
      else if (inc)
        cnt_q <= 16'(cnt_q + 16'h1);
      if (capTake)
        ccp_q <= cnt_q;
      else
      begin
        if (wrCcpL)
          ccp_q[7:0] <= wData_q[7:0];
        if (wrCcpH)
          ccp_q[15:8] <= wData_q[15:8];
      end
      // Hardware sets win over a software clear in the same cycle.
      ovf_q  <= (rollOver && !wrCnt) ||
                (ovf_q && !(wrFlags && wData_q[FLAG_OVF]));
      gev_q  <= gateFell ||
                (gev_q && !(wrFlags && wData_q[FLAG_GEV]));
      cmpf_q <= cmpFire ||
                (cmpf_q && !(wrFlags && wData_q[FLAG_CMP]));
    end
  end

  chk_arm_needs_spm: assert property (@(posedge clk) disable iff (!arst_n)
    arm_q |-> spmEn)
    else $error("arm flag set without single-pulse mode");
  chk_pulse_done: assert property (@(posedge clk) disable iff (!arst_n)
    (spDone && !wrGate) |=> (!arm_q && !spOpen_q))
    else $error("arm flag not cleared at pulse end");
  chk_rollover_flag: assert property (@(posedge clk) disable iff (!arst_n)
    (rollOver && !wrCnt) |=> (cnt_q == 16'h0000) && ovf_q)
    else $error("rollover did not clear count and set flag");
  chk_trig_no_ovf: assert property (@(posedge clk) disable iff (!arst_n)
    (trig && !wrCnt && !ovf_q) |=> (cnt_q == 16'h0000) && !ovf_q)
    else $error("special trigger misbehaved");
  chk_write_wins: assert property (@(posedge clk) disable iff (!arst_n)
    (trig && wrCntL) |=> (cnt_q[7:0] == $past(wData_q[7:0])))
    else $error("count write lost to trigger");
  chk_gate_event: assert property (@(posedge clk) disable iff (!arst_n)
    gateFell |=> gev_q)
    else $error("gate event flag not set");
  chk_gate_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (gateEn && !gateLevel && !wrCnt && !trig) |=> $stable(cnt_q))
    else $error("count moved while gate inactive");
  chk_run_toggle: assert property (@(posedge clk) disable iff (!arst_n)
    !run |=> !toggle_q)
    else $error("toggle stage not cleared while stopped");
  chk_capture_copy: assert property (@(posedge clk) disable iff (!arst_n)
    capTake |=> (ccp_q == $past(cnt_q)))
    else $error("capture did not copy count");
  chk_ovf_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    (ovf_q && !(wrFlags && wData_q[FLAG_OVF])) |=> ovf_q)
    else $error("overflow flag dropped without clear");

endmodule : gsc_counter
`default_nettype wire

//--- gsc_pkg.sv
// Shared constants for the gated sixteen-bit counter.
package gsc_pkg;

  // Register bus geometry.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses.
  localparam logic [7:0] OFF_CTRL  = 8'h00; // counter_control
  localparam logic [7:0] OFF_GATE  = 8'h04; // gate_control
  localparam logic [7:0] OFF_CNTL  = 8'h08; // count_low_byte
  localparam logic [7:0] OFF_CNTH  = 8'h0c; // count_high_byte
  localparam logic [7:0] OFF_CCP   = 8'h10; // capture_compare_pair
  localparam logic [7:0] OFF_CMODE = 8'h14; // capture/compare mode
  localparam logic [7:0] OFF_FLAGS = 8'h18; // peripheral_flag_reg
  localparam logic [7:0] OFF_IEN   = 8'h1c; // enables and irq control

  // Field positions of counter_control.
  localparam int unsigned CTRL_RUN   = 0;
  localparam int unsigned CTRL_SKIP  = 2;
  localparam int unsigned CTRL_XTAL  = 3;
  localparam int unsigned CTRL_PS_LO = 4;
  localparam int unsigned CTRL_CS_LO = 6;

  // Field positions of gate_control.
  localparam int unsigned GATE_ARM = 3;
  localparam int unsigned GATE_NOW = 2;
  localparam int unsigned GATE_SPM = 4;
  localparam int unsigned GATE_TGL = 5;
  localparam int unsigned GATE_POL = 6;
  localparam int unsigned GATE_EN  = 7;

  // Field positions of mode, flag and enable registers.
  localparam int unsigned MODE_CAP  = 0;
  localparam int unsigned MODE_CMP  = 1;
  localparam int unsigned MODE_TRIG = 2;
  localparam int unsigned FLAG_OVF  = 0;
  localparam int unsigned FLAG_GEV  = 1;
  localparam int unsigned FLAG_CMP  = 2;
  localparam int unsigned IEN_OVF   = 0;
  localparam int unsigned IEN_GEV   = 1;
  localparam int unsigned IEN_PERI  = 2;
  localparam int unsigned IEN_GLOB  = 3;

  // Reset values and the count maximum.
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  GATE_RST = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CCP_RST  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;

  // Count source codes.
  localparam logic [1:0] CS_INSTR = 2'h0;
  localparam logic [1:0] CS_SYS   = 2'h1;
  localparam logic [1:0] CS_EXT   = 2'h2;
  localparam logic [1:0] CS_SENSE = 2'h3;

  // Instruction clock is the system clock divided by four.
  localparam logic [1:0] INSTR_LAST = 2'h3;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gsc_pkg

//--- gsc_sync.sv
// Two flip-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module gsc_sync
  import gsc_pkg::*;
#(
  parameter int unsigned W = 1
)(
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         arst_n,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q  <= '0;
      syncOut <= '0;
    end
    else
    begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule : gsc_sync
`default_nettype wire

//--- gsc_prescaler.sv
// Hidden prescale counter dividing count ticks by 1, 2, 4 or 8.
`timescale 1ns/1ps
`default_nettype none
module gsc_prescaler
  import gsc_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control.
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  // Tick in, increment out.
  input  wire logic       tick,
  output logic            inc
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] last;

  // Last count value for the selected ratio.
  assign last  = 3'((4'h1 << sel) - 4'h1);
  assign inc   = tick && (cnt_q == last);
  assign cnt_d = inc ? 3'h0 : 3'(cnt_q + 3'h1);

  // Counter is cleared by a count byte write.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_q <= 3'h0;
    else if (clear)
      cnt_q <= 3'h0;
    else if (tick)
      cnt_q <= cnt_d;
  end

  chk_presc_clear: assert property (@(posedge clk) disable iff (!arst_n)
    clear |=> (cnt_q == 3'h0))
    else $error("prescale counter not cleared");

endmodule : gsc_prescaler
`default_nettype wire

//--- gsc_far_model.sv
// Far-side model: external count pin source and capture event source.
`timescale 1ns/1ps
`default_nettype none
module gsc_far_model (
  // Clock and requests from the bench.
  input  wire logic       clk,
  input  wire logic [7:0] pulses,
  input  wire logic       capReq,
  // Pin and event toward the counter.
  output logic            extCountPin,
  output logic            captureEvent
);
  // The pin rests low between frames and sends whole 320 ns periods.
  initial
  begin
    extCountPin = 1'b0;
    captureEvent = 1'b0;
    forever
    begin
      @(pulses);
      #7;
      repeat (pulses)
      begin
        #160 extCountPin = 1'b1;
        #160 extCountPin = 1'b0;
      end
    end
  end

  // A capture event follows each request one cycle later.
  always @(posedge clk)
    captureEvent <= capReq;
endmodule : gsc_far_model
`default_nettype wire

//--- tb_gsc_counter.sv
// Self-checking testbench for the gated sixteen-bit counter.
`timescale 1ns/1ps
`default_nettype none
module tb_gsc_counter
  import gsc_pkg::*;
;
  logic        clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        extCountPin, captureEvent, gatePin, capReq, sleepMode;
  logic        compareEvent, irqRequest, wakeUp;
  logic [7:0]  awaddr, araddr, pulses;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [65:0] ex;
  logic [65:0] expQ[$];
  string       nameQ[$];
  string       nm;
  logic [15:0] rnd;
  int          mismatches, tests_run, dv, cmpSeen;

  gsc_counter dut_u (.clk, .arst_n, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .extCountPin,
    .crystalClk(extCountPin), .senseOscClk(extCountPin), .gatePin,
    .captureEvent, .sleepMode, .compareEvent, .irqRequest, .wakeUp);

  gsc_far_model far_u (.clk, .pulses, .capReq, .extCountPin, .captureEvent);

  // System clock at 25 MHz.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic check(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // One register write; each channel drops once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      ta = awready && awvalid;
      tw = wready && wvalid;
      tb = bvalid;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!tb);
    bready <= 1'b0;
  endtask : wr

  // One register read; the expectation is queued for the monitor.
  task automatic rd(input logic [7:0] a, input logic [31:0] v, m,
                    input logic [1:0] r, input string n);
    logic ta, tr;
    @(posedge clk);
    expQ.push_back({r, m, v});
    nameQ.push_back(n);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      ta = arready && arvalid;
      tr = rvalid;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    while (!tr);
    rready <= 1'b0;
  endtask : rd

  // Loads both count bytes.
  task automatic setcnt(input logic [15:0] v);
    wr(OFF_CNTL, 32'(v[7:0]));
    wr(OFF_CNTH, 32'(v[15:8]));
  endtask : setcnt

  // Drives one high pulse on the gate pin.
  task automatic gpulse(input int n);
    @(posedge clk);
    gatePin <= 1'b1;
    repeat (n) @(posedge clk);
    gatePin <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : gpulse

  // Counts compare pulses and checks every write response.
  always @(posedge clk)
  begin
    if (compareEvent)
      cmpSeen++;
    if (bvalid && bready)
      check("bresp", 32'(bresp), 32'(RESP_OKAY));
  end

  // Monitor: compares each read answer with the oldest note.
  always @(posedge clk)
    if (rvalid && rready)
    begin
      ex = expQ.pop_front();
      nm = nameQ.pop_front();
      check(nm, rdata & ex[63:32], ex[31:0]);
      check(nm, 32'(rresp), 32'(ex[65:64]));
    end

  // Watchdog against a hang.
  initial
  begin
    #400000;
    mismatches++;
    complete_run();
  end

  // Main sequence of scenarios.
  initial
  begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {gatePin, capReq, sleepMode, pulses, awaddr, araddr, wdata} = '0;
    mismatches = 0;
    cmpSeen = 0;
    tests_run = 0;
    rnd = 16'($urandom(32'h5abc8dcc));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFF_CTRL, 0, '1, RESP_OKAY, "ctrl reset");
    rd(OFF_GATE, 0, 32'hfb, RESP_OKAY, "gate reset");
    rd(8'h20, 0, '1, RESP_SLVERR, "unmapped");
    wr(OFF_GATE, 32'h08);
    rd(OFF_GATE, 0, 32'h08, RESP_OKAY, "arm no spm");
    wr(OFF_GATE, 32'h18);
    rd(OFF_GATE, 32'h18, 32'h18, RESP_OKAY, "armed");
    wr(OFF_GATE, 32'h08);
    rd(OFF_GATE, 0, 32'h08, RESP_OKAY, "arm cleared");
    // Random count write-back, then capture into the pair.
    setcnt(rnd);
    rd(OFF_CNTL, 32'(rnd[7:0]), '1, RESP_OKAY, "count low");
    rd(OFF_CNTH, 32'(rnd[15:8]), '1, RESP_OKAY, "count high");
    wr(OFF_CMODE, 32'h1);
    @(posedge clk) capReq <= 1'b1;
    @(posedge clk) capReq <= 1'b0;
    rd(OFF_CCP, 32'(rnd), 32'hffff, RESP_OKAY, "capture");
    wr(OFF_CMODE, 32'h0);
    // Rollover sets a sticky overflow flag.
    setcnt(16'hfffc);
    wr(OFF_CTRL, 32'h41);
    wr(OFF_CTRL, 32'h00);
    rd(OFF_FLAGS, 1, 1, RESP_OKAY, "ovf set");
    rd(OFF_FLAGS, 1, 1, RESP_OKAY, "ovf sticky");
    rd(OFF_CNTH, 0, '1, RESP_OKAY, "rolled");
    wr(OFF_FLAGS, 32'h1);
    rd(OFF_FLAGS, 0, 1, RESP_OKAY, "ovf clear");
    // Prescale codes on the system clock, then the instruction clock.
    for (int i = 0; i < 5; i++)
    begin
      dv = (i < 4) ? (1 << i) : 4;
      setcnt(16'h0);
      wr(OFF_CTRL, (i < 4) ? 32'h41 | (i << 4) : 32'h01);
      repeat (136 * dv) @(posedge clk);
      wr(OFF_CTRL, 32'h00);
      rd(OFF_CNTL, 32'h80, 32'hf0, RESP_OKAY, "prescale");
      rd(OFF_CNTH, 0, '1, RESP_OKAY, "prescale high");
    end
    // Gate enabled with inactive gate holds the count.
    setcnt(16'h0);
    wr(OFF_GATE, 32'hc0);
    wr(OFF_CTRL, 32'h41);
    repeat (40) @(posedge clk);
    wr(OFF_CTRL, 32'h00);
    rd(OFF_CNTL, 0, '1, RESP_OKAY, "gate hold");
    // Single pulse counts one pulse and ignores the next.
    setcnt(16'h0);
    wr(OFF_GATE, 32'hd0);
    wr(OFF_GATE, 32'hd8);
    wr(OFF_FLAGS, 32'h2);
    wr(OFF_CTRL, 32'h41);
    gpulse(12);
    gpulse(12);
    wr(OFF_CTRL, 32'h00);
    rd(OFF_CNTL, 32'h08, 32'hf8, RESP_OKAY, "one pulse");
    rd(OFF_GATE, 0, 32'h08, RESP_OKAY, "arm done");
    rd(OFF_FLAGS, 2, 2, RESP_OKAY, "gate event");
    // Gate event flag with the gate function off.
    wr(OFF_FLAGS, 32'h2);
    wr(OFF_GATE, 32'h00);
    rd(OFF_GATE, 32'h04, 32'h04, RESP_OKAY, "gate level");
    gpulse(5);
    rd(OFF_FLAGS, 2, 2, RESP_OKAY, "gate event off");
    setcnt(16'h0);
    wr(OFF_IEN, 32'he);
    check("gate irq", 32'(irqRequest), 1);
    // Toggle and single pulse together count one full gate period.
    wr(OFF_GATE, 32'hf0);
    wr(OFF_GATE, 32'hf8);
    wr(OFF_CTRL, 32'h41);
    gpulse(6);
    gpulse(6);
    wr(OFF_CTRL, 32'h00);
    rd(OFF_CNTL, 32'h08, 32'hf8, RESP_OKAY, "toggle pulse");
    wr(OFF_GATE, 32'h00);
    // Pin synced and not, then crystal and sensing sources.
    // Only the pin waits for a falling edge before counting.
    for (int j = 0; j < 4; j++)
    begin
      setcnt(16'h0);
      wr(OFF_CTRL, (j < 2) ? 32'h81 | (j << 2) :
                   (j < 3) ? 32'h89 : 32'hc1);
      @(posedge clk) pulses <= 8'h14;
      repeat (170) @(posedge clk);
      wr(OFF_CTRL, 32'h00);
      pulses <= 8'h00;
      rd(OFF_CNTL, (j < 2) ? 32'h13 : 32'h14, '1, RESP_OKAY,
         "ext source");
    end
    // Special trigger makes the pair a period register.
    wr(OFF_CCP, 32'h9);
    wr(OFF_CMODE, 32'h6);
    setcnt(16'h0);
    wr(OFF_CTRL, 32'h41);
    repeat (50) @(posedge clk);
    wr(OFF_CTRL, 32'h00);
    rd(OFF_CNTL, 0, 32'hf0, RESP_OKAY, "period");
    rd(OFF_FLAGS, 4, 5, RESP_OKAY, "trigger flags");
    check("compare events", cmpSeen, 5);
    // Asleep: unsynchronised pin counting overflows and wakes the part.
    sleepMode <= 1'b1;
    setcnt(16'h0);
    wr(OFF_IEN, 32'h5);
    setcnt(16'hffff);
    wr(OFF_CTRL, 32'h85);
    @(posedge clk) pulses <= 8'h02;
    repeat (30) @(posedge clk);
    check("wake", 32'(wakeUp), 1);
    check("irq no global", 32'(irqRequest), 0);
    wr(OFF_CTRL, 32'h41);
    repeat (20) @(posedge clk);
    wr(OFF_CTRL, 32'h00);
    check("wake needs run", 32'(wakeUp), 0);
    rd(OFF_CNTL, 0, '1, RESP_OKAY, "sleep hold");
    complete_run();
  end
endmodule : tb_gsc_counter
`default_nettype wire
